/* kpi_pkg.sv */
// Package with register map, trigger codes and timing for the key interrupt
package kpi_pkg;
  localparam int KPI_CHANNELS = 8;
  localparam int KPI_ADDR_W = 12;
  // Register indexes; the byte address is four times the index
  localparam logic [7:0] KPI_IDX_CHANNEL_ENABLE = 8'hE9;
  localparam logic [7:0] KPI_IDX_CHANNEL_FLAGS = 8'hEA;
  localparam logic [7:0] KPI_IDX_TRIG_SEL_LOW = 8'hEB;
  localparam logic [7:0] KPI_IDX_TRIG_SEL_HIGH = 8'hEC;
  localparam logic [7:0] KPI_IDX_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] KPI_IDX_IRQ_MASK = 8'hF1;
  localparam logic [1:0] KPI_IDX_LSB = 2'h2;
  localparam logic [7:0] KPI_REG_RESET = 8'h00;
  // Trigger types, coded as {select high, select low}
  localparam logic [1:0] KPI_TRIG_FALL = 2'h0;
  localparam logic [1:0] KPI_TRIG_RISE = 2'h1;
  localparam logic [1:0] KPI_TRIG_EITHER = 2'h2;
  localparam logic [1:0] KPI_TRIG_LOW = 2'h3;
  // AXI responses
  localparam logic [1:0] KPI_RESP_OKAY = 2'h0;
  localparam logic [1:0] KPI_RESP_SLVERR = 2'h2;
  // Flag delay after the pin changes, in machine cycles of one clock
  localparam int KPI_FLAG_DELAY_MCYC = 2;
  localparam int KPI_CLKS_PER_MCYC = 1;
  localparam int KPI_FLAG_DELAY_CYC = KPI_FLAG_DELAY_MCYC * KPI_CLKS_PER_MCYC;
endpackage : kpi_pkg

/* kpi_key_pin_interrupt.sv */
// Key pin interrupt controller with AXI4-Lite register slave
// Summary of operation
// - Eight channels, each a source only when enabled
// - Triggered enabled channel sets flag, requests interrupt
// - Edge flags stay set until software clears
// - Select pair: fall, rise, either, low level
// - Bit x of two select registers per channel
// - Flag rises two machine cycles after trigger
// - Low mode flag is inverse pin, read-only
// - Key request wakes from idle and power-down
// - Enable, flags and selects reset to zero
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module kpi_key_pin_interrupt
  import kpi_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic [kpi_pkg::KPI_CHANNELS-1:0] KEY_INPUT_PORT_I,
  input wire logic [kpi_pkg::KPI_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [kpi_pkg::KPI_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic KEY_REQ_O,
  output logic WAKE_O,
  output logic IRQ_O
);
  import kpi_pkg::*;

  localparam int N = KPI_CHANNELS;

  logic [N-1:0] key_channel_enable;
  logic [N-1:0] key_channel_flags;
  logic [N-1:0] key_trigger_select_low;
  logic [N-1:0] key_trigger_select_high;
  logic [N-1:0] irq_status;
  logic [N-1:0] irq_mask;
  logic [N-1:0] pin_q;
  logic [N-1:0] pin_qq;
  logic [N-1:0] next_flags;
  logic [N-1:0] chan_event;
  logic [N-1:0] flag_clr;

  // Write channel state
  logic aw_held;
  logic w_held;
  logic [KPI_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  // Read channel state
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  // Address decode
  wire [7:0] wr_idx = aw_addr[KPI_IDX_LSB +: 8];
  wire [7:0] rd_idx = S_AXI_ARADDR_I[KPI_IDX_LSB +: 8];
  wire wr_fire = aw_held && w_held && !bvalid;
  wire wr_byte = wr_fire && w_strb[0];
  wire wr_en = wr_byte && (wr_idx == KPI_IDX_CHANNEL_ENABLE);
  wire wr_flags = wr_byte && (wr_idx == KPI_IDX_CHANNEL_FLAGS);
  wire wr_sel_lo = wr_byte && (wr_idx == KPI_IDX_TRIG_SEL_LOW);
  wire wr_sel_hi = wr_byte && (wr_idx == KPI_IDX_TRIG_SEL_HIGH);
  wire wr_status = wr_byte && (wr_idx == KPI_IDX_IRQ_STATUS);
  wire wr_mask = wr_byte && (wr_idx == KPI_IDX_IRQ_MASK);
  wire wr_mapped = (wr_idx == KPI_IDX_CHANNEL_ENABLE) ||
                   (wr_idx == KPI_IDX_CHANNEL_FLAGS) ||
                   (wr_idx == KPI_IDX_TRIG_SEL_LOW) ||
                   (wr_idx == KPI_IDX_TRIG_SEL_HIGH) ||
                   (wr_idx == KPI_IDX_IRQ_STATUS) ||
                   (wr_idx == KPI_IDX_IRQ_MASK);
  wire rd_fire = S_AXI_ARVALID_I && !rvalid;
  wire rd_en = rd_idx == KPI_IDX_CHANNEL_ENABLE;
  wire rd_flags = rd_idx == KPI_IDX_CHANNEL_FLAGS;
  wire rd_sel_lo = rd_idx == KPI_IDX_TRIG_SEL_LOW;
  wire rd_sel_hi = rd_idx == KPI_IDX_TRIG_SEL_HIGH;
  wire rd_status = rd_idx == KPI_IDX_IRQ_STATUS;
  wire rd_mask = rd_idx == KPI_IDX_IRQ_MASK;
  wire rd_mapped = rd_en || rd_flags || rd_sel_lo || rd_sel_hi ||
                   rd_status || rd_mask;
  wire [N-1:0] rd_value = rd_en ? key_channel_enable :
                          rd_flags ? key_channel_flags :
                          rd_sel_lo ? key_trigger_select_low :
                          rd_sel_hi ? key_trigger_select_high :
                          rd_status ? irq_status :
                          rd_mask ? irq_mask : '0;
  wire [N-1:0] wr_byte_data = w_data[N-1:0];

  // Handshake outputs
  assign S_AXI_AWREADY_O = !aw_held;
  assign S_AXI_WREADY_O = !w_held;
  assign S_AXI_BVALID_O = bvalid;
  assign S_AXI_BRESP_O = bresp;
  assign S_AXI_ARREADY_O = !rvalid;
  assign S_AXI_RVALID_O = rvalid;
  assign S_AXI_RDATA_O = rdata;
  assign S_AXI_RRESP_O = rresp;

  // Shared request, also the wake-up source
  assign KEY_REQ_O = |(key_channel_flags & key_channel_enable);
  assign WAKE_O = KEY_REQ_O;
  assign IRQ_O = |(irq_status & irq_mask);

  // Writing zero to an edge flag clears it
  assign flag_clr = wr_flags ? ~wr_byte_data : '0;

  // Per-channel trigger detection
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_chan
      wire [1:0] mode = {key_trigger_select_high[i],
                         key_trigger_select_low[i]};
      wire fall = pin_qq[i] && !pin_q[i];
      wire rise = !pin_qq[i] && pin_q[i];
      wire level = mode == KPI_TRIG_LOW;
      wire hit = (mode == KPI_TRIG_FALL) ? fall :
                 (mode == KPI_TRIG_RISE) ? rise :
                 (mode == KPI_TRIG_EITHER) ? (fall || rise) :
                 !pin_q[i];
      assign chan_event[i] = key_channel_enable[i] && hit;
      // Level mode tracks the pin, edge set wins over clear
      assign next_flags[i] = level ? !pin_q[i] :
                             chan_event[i] ? 1'b1 :
                             flag_clr[i] ? 1'b0 : key_channel_flags[i];

      a_edge_sets_flag: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (!KEY_INPUT_PORT_I[i] && pin_q[i] && key_channel_enable[i] &&
         mode == KPI_TRIG_FALL && !wr_en && !wr_sel_lo && !wr_sel_hi)
        |-> ##2 key_channel_flags[i])
        else $error("Falling edge did not set flag in two cycles");
      a_disabled_quiet: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (!key_channel_enable[i] && !level && !key_channel_flags[i])
        |=> !key_channel_flags[i])
        else $error("Disabled channel raised an edge flag");
      a_level_follow: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        level |=> key_channel_flags[i] == !$past(pin_q[i]))
        else $error("Low level flag does not follow inverse pin");
      a_flag_sticky: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (key_channel_flags[i] && !level && !flag_clr[i])
        |=> key_channel_flags[i])
        else $error("Edge flag dropped without a clear");
      a_rise_mode: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (mode == KPI_TRIG_RISE && key_channel_enable[i] && fall &&
         !key_channel_flags[i]) |=> !key_channel_flags[i])
        else $error("Rising mode flagged a falling edge");
      a_flag_clear: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (key_channel_flags[i] && !level && flag_clr[i] && !chan_event[i])
        |=> !key_channel_flags[i])
        else $error("Edge flag not cleared by software write");
      // Status and wake-up follow every enabled trigger
      a_status_set: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        chan_event[i] |=> irq_status[i])
        else $error("Channel event did not set its status bit");
      a_status_kept: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (irq_status[i] && !(wr_status && wr_byte_data[i]))
        |=> irq_status[i])
        else $error("Status bit dropped without a clear");
      a_wake_any: assert property (@(posedge CLOCK_I)
        disable iff (!RST_N_I)
        (key_channel_flags[i] && key_channel_enable[i]) |-> WAKE_O)
        else $error("Enabled flag did not raise wake-up");
    end
  endgenerate

  // Pin sampling pipeline
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      pin_q <= '1;
      pin_qq <= '1;
    end else begin
      pin_q <= KEY_INPUT_PORT_I;
      pin_qq <= pin_q;
    end
  end

  // Channel registers
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      key_channel_enable <= KPI_REG_RESET;
      key_channel_flags <= KPI_REG_RESET;
      key_trigger_select_low <= KPI_REG_RESET;
      key_trigger_select_high <= KPI_REG_RESET;
    end else begin
      key_channel_flags <= next_flags;
      if (wr_en) begin
        key_channel_enable <= wr_byte_data;
      end
      if (wr_sel_lo) begin
        key_trigger_select_low <= wr_byte_data;
      end
      if (wr_sel_hi) begin
        key_trigger_select_high <= wr_byte_data;
      end
    end
  end

  // Sticky status, write one to clear, new event wins
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      irq_status <= KPI_REG_RESET;
      irq_mask <= KPI_REG_RESET;
    end else begin
      irq_status <= chan_event |
                    (irq_status & ~(wr_status ? wr_byte_data : '0));
      if (wr_mask) begin
        irq_mask <= wr_byte_data;
      end
    end
  end

  // AXI write path
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= KPI_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && !w_held) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? KPI_RESP_OKAY : KPI_RESP_SLVERR;
      end else if (bvalid && S_AXI_BREADY_I) begin
        bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // AXI read path
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= KPI_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata <= {{(32 - N){1'b0}}, rd_value};
      rresp <= rd_mapped ? KPI_RESP_OKAY : KPI_RESP_SLVERR;
    end else if (rvalid && S_AXI_RREADY_I) begin
      rvalid <= 1'b0;
    end
  end

  a_reset_clears: assert property (@(posedge CLOCK_I)
    !RST_N_I |=> (key_channel_enable == '0 && key_channel_flags == '0 &&
                  key_trigger_select_low == '0 &&
                  key_trigger_select_high == '0))
    else $error("Registers not zero after reset");
  a_request_held: assert property (@(posedge CLOCK_I)
    disable iff (!RST_N_I)
    (KEY_REQ_O && key_channel_flags == $past(key_channel_flags) &&
     key_channel_enable == $past(key_channel_enable)) |-> $past(KEY_REQ_O))
    else $error("Request changed with flags and enables steady");
  a_wake_request: assert property (@(posedge CLOCK_I)
    disable iff (!RST_N_I)
    (key_channel_flags[0] && key_channel_enable[0]) |-> WAKE_O)
    else $error("Enabled flag did not raise wake-up");
  a_write_answer: assert property (@(posedge CLOCK_I)
    disable iff (!RST_N_I)
    (aw_held && w_held && !bvalid) |=> bvalid)
    else $error("Write response late");
  a_read_answer: assert property (@(posedge CLOCK_I)
    disable iff (!RST_N_I)
    (S_AXI_ARVALID_I && !rvalid) |=> rvalid)
    else $error("Read response late");
endmodule : kpi_key_pin_interrupt
`default_nettype wire

/* kpi_keypad_model.sv */
// Keypad switch model driving the key pins
`timescale 1ns/10ps
`default_nettype none
module kpi_keypad_model (
  input wire logic [7:0] press_i,
  output logic [7:0] pin_o
);
  // Pressed key pulls low, pull-up holds a free pin high
  assign pin_o = ~press_i;
endmodule : kpi_keypad_model
`default_nettype wire

/* test_keypad_pin_interrupt.sv */
// Testbench for the key pin interrupt controller
`timescale 1ns/10ps
`default_nettype none
module test_keypad_pin_interrupt;
  import kpi_pkg::*;
  logic clk = 0;
  logic rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wda = '0;
  logic [7:0] press = '0;
  wire logic [7:0] pin;
  wire logic [31:0] rdata;
  wire logic [1:0] bresp, rresp;
  wire logic awr, wr, bv, arr, rv, kreq, wake, irq;
  int err_total = 0, cmp_count = 0;
  kpi_keypad_model keys (.press_i(press), .pin_o(pin));
  kpi_key_pin_interrupt dut (.CLOCK_I(clk), .RST_N_I(rst_n),
    .KEY_INPUT_PORT_I(pin), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wda), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
    .KEY_REQ_O(kreq), .WAKE_O(wake), .IRQ_O(irq));
  initial forever #2.5 clk = ~clk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  // Write one register; bready stays high until the response is seen
  task automatic axw(input logic [7:0] ix, d, output logic [1:0] r);
    logic ha, hw, hb;
    hb = 0;
    @(posedge clk);
    awa <= {2'h0, ix, 2'h0};
    wda <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    for (int n = 0; n < 40 && !hb; n++) begin
      #1;
      ha = awv & awr;
      hw = wv & wr;
      hb = bv;
      r = bresp;
      @(posedge clk);
      if (ha) awv <= 0;
      if (hw) wv <= 0;
      if (hb) bry <= 0;
    end
    if (!hb) begin
      err_total++;
      finish_test();
    end
  endtask : axw
  task automatic axr(input logic [7:0] ix, output logic [31:0] d,
                     output logic [1:0] r);
    logic ha, hr;
    hr = 0;
    @(posedge clk);
    ara <= {2'h0, ix, 2'h0};
    arv <= 1;
    rry <= 1;
    for (int n = 0; n < 40 && !hr; n++) begin
      #1;
      ha = arv & arr;
      hr = rv;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ha) arv <= 0;
      if (hr) rry <= 0;
    end
    if (!hr) begin
      err_total++;
      finish_test();
    end
  endtask : axr
  task automatic rdchk(input logic [7:0] ix, e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    axr(ix, d, r);
    chk(nm, d, {24'h0, e});
  endtask : rdchk
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++)
      rdchk(KPI_IDX_CHANNEL_ENABLE + 8'(i), 8'h00, "reset reg");
    rdchk(KPI_IDX_IRQ_STATUS, 8'h00, "status reset");
    rdchk(KPI_IDX_IRQ_MASK, 8'h00, "mask reset");
    chk("key_req reset", kreq, 0);
    axw(8'h10, 8'h55, r);
    chk("bresp unmapped", r, KPI_RESP_SLVERR);
    axr(8'h10, d, r);
    chk("rresp unmapped", r, KPI_RESP_SLVERR);
    chk("rdata unmapped", d, 0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_edge;
    logic [1:0] r;
    axw(KPI_IDX_CHANNEL_ENABLE, 8'h01, r);
    press <= 8'h03;
    tick();
    chk("key_req early", kreq, 0);
    tick();
    chk("key_req", kreq, 1);
    chk("wake", wake, 1);
    @(posedge clk);
    press <= 8'h00;
    rdchk(KPI_IDX_CHANNEL_FLAGS, 8'h01, "flags held");
    axw(KPI_IDX_CHANNEL_FLAGS, 8'h00, r);
    tick();
    chk("key_req clear", kreq, 0);
    $display("edge test done");
  endtask : t_edge
  // Channel n uses mode n mod 4: fall, rise, either, low level
  task automatic t_modes;
    logic [1:0] r;
    axw(KPI_IDX_TRIG_SEL_LOW, 8'hAA, r);
    axw(KPI_IDX_TRIG_SEL_HIGH, 8'hCC, r);
    axw(KPI_IDX_CHANNEL_ENABLE, 8'hFF, r);
    press <= 8'hFF;
    repeat (3) tick();
    rdchk(KPI_IDX_CHANNEL_FLAGS, 8'hDD, "flags fall");
    axw(KPI_IDX_CHANNEL_FLAGS, 8'h00, r);
    rdchk(KPI_IDX_CHANNEL_FLAGS, 8'h88, "flags level");
    @(posedge clk);
    press <= 8'h00;
    repeat (3) tick();
    axw(KPI_IDX_CHANNEL_FLAGS, 8'hFF, r);
    rdchk(KPI_IDX_CHANNEL_FLAGS, 8'h66, "flags rise");
    $display("modes test done");
  endtask : t_modes
  task automatic t_irq;
    logic [1:0] r;
    rdchk(KPI_IDX_IRQ_STATUS, 8'hFF, "status");
    tick();
    chk("irq masked", irq, 0);
    axw(KPI_IDX_IRQ_MASK, 8'h10, r);
    tick();
    chk("irq", irq, 1);
    axw(KPI_IDX_IRQ_STATUS, 8'hEF, r);
    tick();
    chk("irq kept", irq, 1);
    axw(KPI_IDX_IRQ_STATUS, 8'h10, r);
    tick();
    chk("irq clear", irq, 0);
    rdchk(KPI_IDX_IRQ_STATUS, 8'h00, "status clear");
    $display("irq test done");
  endtask : t_irq
  // Reset in mid-run returns the channel registers, mask, key request and irq to zero
  task automatic t_rerun;
    press <= 8'h01;
    repeat (3) tick();
    chk("key_req before reset", kreq, 1);
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    tick();
    chk("key_req after reset", kreq, 0);
    chk("irq after reset", irq, 0);
    for (int i = 0; i < 4; i++)
      rdchk(KPI_IDX_CHANNEL_ENABLE + 8'(i), 8'h00, "rerun reg");
    rdchk(KPI_IDX_IRQ_MASK, 8'h00, "rerun mask");
    press <= 8'h00;
    $display("mid-run reset test done");
  endtask : t_rerun
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_edge();
    t_modes();
    t_irq();
    t_rerun();
    finish_test();
  end
endmodule : test_keypad_pin_interrupt
`default_nettype wire
